/* shared/acc_pkg.sv */
package acc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] ACC_IDX_INPUT_SELECT     = 8'h00;
    localparam logic [7:0] ACC_IDX_CONTROL_A        = 8'h01;
    localparam logic [7:0] ACC_IDX_CONTROL_B        = 8'h02;
    localparam logic [7:0] ACC_IDX_RESULT_LOW       = 8'h03;
    localparam logic [7:0] ACC_IDX_RESULT_HIGH      = 8'h04;
    localparam logic [7:0] ACC_IDX_DIGITAL_DISABLE  = 8'h0d;

    // Input select fields
    localparam int ACC_CHAN_LSB   = 0;
    localparam int ACC_REF_BIT    = 4;
    // Control A fields
    localparam int ACC_EN_BIT     = 7;
    localparam int ACC_START_BIT  = 6;
    localparam int ACC_AUTO_BIT   = 5;
    localparam int ACC_DONE_BIT   = 4;
    localparam int ACC_IRQEN_BIT  = 3;
    localparam int ACC_PS_LSB     = 0;
    // Control B fields
    localparam int ACC_LEFT_BIT   = 7;
    localparam int ACC_CME_BIT    = 6;
    localparam int ACC_TS_LSB     = 0;

    // Reset values
    localparam logic [3:0] ACC_CHAN_RESET             = 4'h0;
    localparam logic [2:0] ACC_PS_RESET               = 3'h0;
    localparam logic [2:0] ACC_TS_RESET               = 3'h0;
    localparam logic [7:0] ACC_DIGITAL_DISABLE_RESET  = 8'h00;
    localparam logic [9:0] ACC_RESULT_RESET           = 10'h000;

    // Conversion timing in converter clock cycles
    localparam logic [4:0] ACC_FIRST_CONV_CYCLES  = 5'h19;
    localparam logic [4:0] ACC_NORMAL_CONV_CYCLES = 5'h0d;
    localparam logic [4:0] ACC_FIRST_SAMPLE_CYC   = 5'h0d;
    localparam logic [4:0] ACC_NORMAL_SAMPLE_CYC  = 5'h01;

    // Trigger source zero is the completion flag: free running
    localparam logic [2:0] ACC_TS_FREE_RUN = 3'h0;
    localparam logic [3:0] ACC_CHAN_TEMP   = 4'h8;

    typedef enum logic {ACC_IDLE, ACC_CONVERT} acc_state_e;

    typedef struct packed {
        logic       enable;
        logic       sample;
        logic [3:0] channel;
        logic       ref_internal;
    } acc_core_s;

    typedef struct packed {
        logic       write;
        logic [7:0] idx;
    } acc_aphase_s;
endpackage : acc_pkg

/* rtl/acc_conversion_control.sv */
`timescale 1ns/10ps
// Behaviour
// - Converter idle until enable set; clearing enable stops any conversion.
// - Reference and channel selections reach the core only while enabled.
// - Each conversion yields a 10-bit code, zero ground, all ones reference.
// - Reference select picks supply or internal 1.1V reference.
// - Channel select routes one of eight pins or temperature sensor.
// - Result right aligned by default, left aligned when left adjust set.
// - Reading low byte locks result; completions before high read are dropped.
// - Reading high byte releases the result lock.
// - Completion flag still sets when the result is dropped by lock.
// - Writing start one begins a conversion; reads one until completion.
// - Channel change during conversion applies only after it finishes.
// - Auto trigger enable makes the selected trigger source start conversions.
// - Rising trigger edge resets prescaler and starts a conversion.
// - Trigger held high at completion or edge during conversion starts nothing.
// - Trigger flags set even if masked; software clears them before next event.
// - Completion-flag trigger restarts after each conversion; first needs start bit.
// - Start bit works under auto trigger and reads one during any conversion.
// - Comparator mux enable with converter off routes channel mux to comparator.
// - Digital disable bit blocks pin input, reads zero; resets to zero.
// - Converter raises its own interrupt request on completion.
// - Normal conversion 13 converter cycles; first after enable 25.
// - Start bit conversion begins on next converter clock edge.
// - Completion writes result, sets flag, clears start bit same cycle; free running keeps start bit one.
module acc_conversion_control
    import acc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output acc_core_s        core,
    input  wire logic [9:0]  core_result,
    input  wire logic [7:0]  trigger_in,
    output logic             conversion_irq,
    output logic             comparator_mux_sel,
    output logic [3:0]       comparator_channel,
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_read,
    output logic [7:0]       digital_input_disable
);
    logic [3:0]  chan_temp;
    logic        ref_temp;
    logic [3:0]  active_chan;
    logic        active_ref;
    logic        converter_enable;
    logic        start_req;
    logic        auto_trigger_enable;
    logic        conversion_done_flag;
    logic        irq_enable;
    logic [2:0]  prescale_select;
    logic        left_adjust_select;
    logic        comparator_mux_enable;
    logic [2:0]  trigger_source_select;
    logic [9:0]  result;
    logic        read_lock;
    acc_state_e  state;
    logic [4:0]  cyc;
    logic        conv_first;
    logic [7:0]  ps_cnt;
    logic [8:0]  ps_div;
    logic        tick;
    logic        trig_q;
    logic        trig_edge;
    logic        begin_manual;
    logic        begin_trig;
    logic        done;
    logic        free_run;
    logic [4:0]  conv_len;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
    acc_aphase_s dp;
    logic        take;
    logic        addr_ok;
    logic        rd_low;
    logic        rd_high;
    logic        wr_sel;
    logic        wr_ctl_a;
    logic        wr_ctl_b;
    logic        wr_dis;
    logic [7:0]  res_low_byte;
    logic [7:0]  res_high_byte;
    logic [31:0] next_rdata;

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign take    = hsel & hready & htrans[1];
    assign addr_ok = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'b00);
    // Read side effects act on the address phase, so the lock is in place before data returns
    assign rd_low  = take & ~hwrite & addr_ok & (haddr[9:2] == ACC_IDX_RESULT_LOW);
    assign rd_high = take & ~hwrite & addr_ok & (haddr[9:2] == ACC_IDX_RESULT_HIGH);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp <= '0;
        end else begin
            dp.write <= take & hwrite & addr_ok;
            dp.idx   <= haddr[9:2];
        end
    end

    assign wr_sel   = dp.write & (dp.idx == ACC_IDX_INPUT_SELECT);
    assign wr_ctl_a = dp.write & (dp.idx == ACC_IDX_CONTROL_A);
    assign wr_ctl_b = dp.write & (dp.idx == ACC_IDX_CONTROL_B);
    assign wr_dis   = dp.write & (dp.idx == ACC_IDX_DIGITAL_DISABLE);

    // Alignment is applied on read so the stored code is always the raw 10 bits
    assign res_low_byte  = left_adjust_select ? {result[1:0], 6'h00} : result[7:0];
    assign res_high_byte = left_adjust_select ? result[9:2] : {6'h00, result[9:8]};

    always_comb begin
        next_rdata = 32'h00000000;
        if (addr_ok) begin
            unique case (haddr[9:2])
                ACC_IDX_INPUT_SELECT:    next_rdata[4:0] = {ref_temp, chan_temp};
                ACC_IDX_CONTROL_A:       next_rdata[7:0] = {converter_enable, start_req | (state == ACC_CONVERT),
                                                            auto_trigger_enable, conversion_done_flag,
                                                            irq_enable, prescale_select};
                ACC_IDX_CONTROL_B:       next_rdata[7:0] = {left_adjust_select, comparator_mux_enable, 3'h0,
                                                            trigger_source_select};
                ACC_IDX_RESULT_LOW:      next_rdata[7:0] = res_low_byte;
                ACC_IDX_RESULT_HIGH:     next_rdata[7:0] = res_high_byte;
                ACC_IDX_DIGITAL_DISABLE: next_rdata[7:0] = digital_input_disable;
                default:                 next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take & ~hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Software-side selection, held in the temporary copy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_temp <= ACC_CHAN_RESET;
            ref_temp  <= 1'b0;
        end else if (wr_sel) begin
            chan_temp <= hwdata[ACC_CHAN_LSB +: 4];
            ref_temp  <= hwdata[ACC_REF_BIT];
        end
    end

    // Copy follows the temporary only while enabled and not mid-conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_chan <= ACC_CHAN_RESET;
            active_ref  <= 1'b0;
        end else if (converter_enable & ((state == ACC_IDLE) | done)) begin
            active_chan <= chan_temp;
            active_ref  <= ref_temp;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converter_enable    <= 1'b0;
            auto_trigger_enable <= 1'b0;
            irq_enable          <= 1'b0;
            prescale_select     <= ACC_PS_RESET;
        end else if (wr_ctl_a) begin
            converter_enable    <= hwdata[ACC_EN_BIT];
            auto_trigger_enable <= hwdata[ACC_AUTO_BIT];
            irq_enable          <= hwdata[ACC_IRQEN_BIT];
            prescale_select     <= hwdata[ACC_PS_LSB +: 3];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_adjust_select    <= 1'b0;
            comparator_mux_enable <= 1'b0;
            trigger_source_select <= ACC_TS_RESET;
        end else if (wr_ctl_b) begin
            left_adjust_select    <= hwdata[ACC_LEFT_BIT];
            comparator_mux_enable <= hwdata[ACC_CME_BIT];
            trigger_source_select <= hwdata[ACC_TS_LSB +: 3];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            digital_input_disable <= ACC_DIGITAL_DISABLE_RESET;
        end else if (wr_dis) begin
            digital_input_disable <= hwdata[7:0];
        end
    end

    // Prescaler: divide by two to the power one plus select, held in reset while disabled
    assign ps_div = 9'h002 << prescale_select;
    assign tick   = ({1'b0, ps_cnt} == (ps_div - 9'h001));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ps_cnt <= 8'h00;
        end else if (!converter_enable | begin_trig | tick) begin
            ps_cnt <= 8'h00;
        end else begin
            ps_cnt <= ps_cnt + 8'h01;
        end
    end

    // Edge detect only; a level still high after completion gives no new start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trigger_in[trigger_source_select];
        end
    end

    assign trig_edge    = trigger_in[trigger_source_select] & ~trig_q;
    assign free_run     = auto_trigger_enable & (trigger_source_select == ACC_TS_FREE_RUN);
    assign begin_trig   = converter_enable & (state == ACC_IDLE) & auto_trigger_enable &
                          (trigger_source_select != ACC_TS_FREE_RUN) & trig_edge;
    assign begin_manual = converter_enable & (state == ACC_IDLE) & start_req & tick & ~begin_trig;
    assign conv_len     = conv_first ? ACC_FIRST_CONV_CYCLES : ACC_NORMAL_CONV_CYCLES;
    // Gated by enable so a clear written before the completing tick cannot store a result or set the flag
    assign done         = converter_enable & (state == ACC_CONVERT) & tick & (cyc == conv_len - 5'h01);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_req <= 1'b0;
        end else if (!converter_enable & !(wr_ctl_a & hwdata[ACC_EN_BIT])) begin
            start_req <= 1'b0;
        end else if (begin_manual | begin_trig) begin
            start_req <= 1'b0;
        end else if (wr_ctl_a & hwdata[ACC_START_BIT] & hwdata[ACC_EN_BIT] & (state == ACC_IDLE)) begin
            start_req <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= ACC_IDLE;
            cyc        <= 5'h00;
            conv_first <= 1'b1;
        end else if (!converter_enable) begin
            state      <= ACC_IDLE;
            cyc        <= 5'h00;
            conv_first <= 1'b1;
        end else if (begin_manual | begin_trig) begin
            state <= ACC_CONVERT;
            cyc   <= 5'h00;
        end else if (done) begin
            // Free running keeps busy high, so the start bit stays one
            state      <= free_run ? ACC_CONVERT : ACC_IDLE;
            cyc        <= 5'h00;
            conv_first <= 1'b0;
        end else if ((state == ACC_CONVERT) & tick) begin
            cyc <= cyc + 5'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result <= ACC_RESULT_RESET;
        end else if (done & ~read_lock) begin
            result <= core_result;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_lock <= 1'b0;
        end else if (rd_high) begin
            read_lock <= 1'b0;
        end else if (rd_low) begin
            read_lock <= 1'b1;
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conversion_done_flag <= 1'b0;
        end else if (done) begin
            conversion_done_flag <= 1'b1;
        end else if (wr_ctl_a & hwdata[ACC_DONE_BIT]) begin
            conversion_done_flag <= 1'b0;
        end
    end

    assign conversion_irq = conversion_done_flag & irq_enable;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core <= '0;
        end else begin
            core.enable       <= converter_enable;
            core.sample       <= converter_enable & (state == ACC_CONVERT) & tick &
                                 (cyc == (conv_first ? ACC_FIRST_SAMPLE_CYC : ACC_NORMAL_SAMPLE_CYC));
            core.channel      <= active_chan;
            core.ref_internal <= active_ref;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comparator_mux_sel <= 1'b0;
            comparator_channel <= ACC_CHAN_RESET;
        end else begin
            comparator_mux_sel <= comparator_mux_enable & ~converter_enable;
            comparator_channel <= chan_temp;
        end
    end

    // Pins are asynchronous: two stages before the mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1   <= 8'h00;
            pin_s2   <= 8'h00;
            pin_read <= 8'h00;
        end else begin
            pin_s1   <= pin_in;
            pin_s2   <= pin_s1;
            pin_read <= pin_s2 & ~digital_input_disable;
        end
    end

    chk_off_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !converter_enable |=> (state == ACC_IDLE) && !core.sample)
        else $error("conversion running while disabled");
    chk_sel_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !converter_enable |=> $stable(active_chan) && $stable(active_ref))
        else $error("selection applied while disabled");
    chk_chan_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == ACC_CONVERT) && !done |=> $stable(active_chan))
        else $error("channel changed mid conversion");
    chk_result_store: assert property (@(posedge hclk) disable iff (!hresetn)
        done && !read_lock |=> result == $past(core_result))
        else $error("result not stored");
    chk_lock_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        read_lock && !rd_high |=> $stable(result))
        else $error("locked result changed");
    chk_lock_free: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_high |=> !read_lock)
        else $error("lock not released");
    chk_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
        done |=> conversion_done_flag)
        else $error("completion flag missing");
    chk_trig_start: assert property (@(posedge hclk) disable iff (!hresetn)
        begin_trig |=> (state == ACC_CONVERT) && (ps_cnt == 8'h00) && (cyc == 5'h00))
        else $error("trigger did not start conversion");
    chk_free_run: assert property (@(posedge hclk) disable iff (!hresetn)
        done && free_run && converter_enable |=> state == ACC_CONVERT)
        else $error("free running did not restart");
    chk_first_len: assert property (@(posedge hclk) disable iff (!hresetn)
        done |-> (conv_first ? (cyc == 5'h18) : (cyc == 5'h0c)))
        else $error("conversion length wrong");
    chk_busy_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == ACC_CONVERT) && take && !hwrite && addr_ok && (haddr[9:2] == ACC_IDX_CONTROL_A)
        |=> hrdata[ACC_START_BIT])
        else $error("start bit reads zero while busy");
    chk_pin_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (pin_read & $past(digital_input_disable)) == 8'h00)
        else $error("disabled pin reads one");

    cov_first_done: cover property (@(posedge hclk) disable iff (!hresetn) done && conv_first);
    cov_lost_result: cover property (@(posedge hclk) disable iff (!hresetn) done && read_lock);
    cov_trig_run: cover property (@(posedge hclk) disable iff (!hresetn) begin_trig ##[1:400] done);
    cov_free_again: cover property (@(posedge hclk) disable iff (!hresetn) done && free_run);
endmodule : acc_conversion_control

/* verification/acc_core_model.sv */
`timescale 1ns/10ps
// Analog core stand-in: the code encodes the applied reference and channel, so a wrong
// selection shows up in the result registers
module acc_core_model
    import acc_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  acc_core_s       core,
    output logic [9:0]      core_result
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_result <= 10'h3ff;
        end else if (!core.enable) begin
            core_result <= ~core_result; // Unpowered core gives no stable code
        end else if (core.sample) begin
            core_result <= {core.ref_internal, core.channel, 5'h0b};
        end
    end
endmodule : acc_core_model

/* verification/testbench.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module testbench;
    import acc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    acc_core_s   core;
    logic [9:0]  core_result;
    logic [7:0]  trigger_in, pin_in, pin_read, digital_input_disable;
    logic        conversion_irq, comparator_mux_sel;
    logic [3:0]  comparator_channel;
    logic [31:0] rd, lo;
    int          errors, checks_done;

    acc_conversion_control u_acc_conversion_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core(core),
        .core_result(core_result), .trigger_in(trigger_in), .conversion_irq(conversion_irq),
        .comparator_mux_sel(comparator_mux_sel), .comparator_channel(comparator_channel),
        .pin_in(pin_in), .pin_read(pin_read), .digital_input_disable(digital_input_disable));
    acc_core_model u_acc_core_model (.hclk(hclk), .hresetn(hresetn), .core(core),
        .core_result(core_result));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    // Polls the start bit; the completion time is never assumed
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            xfer(1'b0, ACC_IDX_CONTROL_A, 32'h0);
            n++;
        end while (rd[ACC_START_BIT] === 1'b1 && n < 300);
        `CHK("start bit cleared", 1'b0, rd[ACC_START_BIT])
        `CHK("done flag", 1'b1, rd[ACC_DONE_BIT])
    endtask : wait_done

    task automatic convert(input logic [7:0] sel);
        xfer(1'b1, ACC_IDX_INPUT_SELECT, {24'h0, sel});
        xfer(1'b1, ACC_IDX_CONTROL_A, 32'h0000_00d8);
        xfer(1'b0, ACC_IDX_CONTROL_A, 32'h0);
        `CHK("start reads busy", 1'b1, rd[ACC_START_BIT])
        wait_done();
    endtask : convert

    task automatic summarize;
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    initial begin
        #160000;
        errors++;
        summarize();
    end

    initial begin
        logic [7:0] sels [3];
        logic [9:0] r;
        sels = '{8'h00, 8'h17, 8'h08};
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = 3'h2;
        hwdata = '0; trigger_in = '0; pin_in = 8'ha5; errors = 0; checks_done = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, ACC_IDX_DIGITAL_DISABLE, 32'h0);
        `CHK("disable reset", 32'h0, rd)
        xfer(1'b0, 8'h3f, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        `CHK("response okay", 1'b0, hresp)
        repeat (4) @(posedge hclk);
        `CHK("converter idle", 1'b0, core.enable)
        xfer(1'b1, ACC_IDX_DIGITAL_DISABLE, 32'h0000_000f);
        repeat (5) @(posedge hclk);
        `CHK("pin read masked", 8'ha0, pin_read)
        `CHK("disable out", 8'h0f, digital_input_disable)
        xfer(1'b1, ACC_IDX_CONTROL_B, 32'h0000_0040);
        repeat (2) @(posedge hclk);
        `CHK("comparator mux", 1'b1, comparator_mux_sel)
        foreach (sels[i]) begin
            convert(sels[i]);
            r = {sels[i][4], sels[i][3:0], 5'h0b};
            `CHK("irq level", 1'b1, conversion_irq)
            `CHK("comparator back", 1'b0, comparator_mux_sel)
            `CHK("comparator channel", sels[i][3:0], comparator_channel)
            xfer(1'b0, ACC_IDX_RESULT_LOW, 32'h0);
            `CHK("low right", {24'h0, r[7:0]}, rd)
            xfer(1'b0, ACC_IDX_RESULT_HIGH, 32'h0);
            `CHK("high right", {30'h0, r[9:8]}, rd)
        end
        xfer(1'b1, ACC_IDX_CONTROL_B, 32'h0000_0080);
        convert(8'h03);
        xfer(1'b0, ACC_IDX_RESULT_HIGH, 32'h0);
        `CHK("high left", 32'h0000_001a, rd)
        xfer(1'b0, ACC_IDX_RESULT_LOW, 32'h0);
        lo = rd;
        `CHK("low left", 32'h0000_00c0, rd)
        // Low byte read holds the lock across a whole conversion on another channel
        convert(8'h05);
        xfer(1'b0, ACC_IDX_RESULT_LOW, 32'h0);
        `CHK("low locked", lo, rd)
        xfer(1'b0, ACC_IDX_RESULT_HIGH, 32'h0);
        `CHK("high locked", 32'h0000_001a, rd)
        convert(8'h05);
        xfer(1'b0, ACC_IDX_RESULT_HIGH, 32'h0);
        `CHK("high unlocked", 32'h0000_002a, rd)
        xfer(1'b1, ACC_IDX_CONTROL_A, 32'h0000_0018);
        xfer(1'b0, ACC_IDX_CONTROL_A, 32'h0);
        `CHK("flag cleared", 1'b0, rd[ACC_DONE_BIT])
        // Trigger source one, held high past completion
        xfer(1'b1, ACC_IDX_CONTROL_B, 32'h0000_0001);
        xfer(1'b1, ACC_IDX_CONTROL_A, 32'h0000_00a8);
        @(posedge hclk);
        trigger_in <= 8'h02;
        xfer(1'b0, ACC_IDX_CONTROL_A, 32'h0);
        `CHK("triggered busy", 1'b1, rd[ACC_START_BIT])
        wait_done();
        repeat (60) @(posedge hclk);
        xfer(1'b0, ACC_IDX_CONTROL_A, 32'h0);
        `CHK("no retrigger", 1'b0, rd[ACC_START_BIT])
        trigger_in <= 8'h00;
        // Free running: flag left set yet conversions keep coming
        xfer(1'b1, ACC_IDX_CONTROL_B, 32'h0);
        xfer(1'b1, ACC_IDX_CONTROL_A, 32'h0000_00e8);
        repeat (80) @(posedge hclk);
        xfer(1'b0, ACC_IDX_CONTROL_A, 32'h0);
        `CHK("free running", 1'b1, rd[ACC_START_BIT])
        xfer(1'b1, ACC_IDX_CONTROL_A, 32'h0);
        repeat (3) @(posedge hclk);
        `CHK("stopped", 1'b0, core.enable)
        summarize();
    end
endmodule : testbench
